// [cfg_field.sv]
`timescale 1ns/1ps
`default_nettype none

module cfg_field
  import port_cfg_pkg::*;
#(
  parameter logic [REG_W-1:0] MASK = 8'hFF
) (
  input wire logic clk, // System clock
  input wire logic reset, // Asynchronous reset, active high
  input wire logic wr, // Write strobe for this field
  input wire logic [REG_W-1:0] wdata, // Write data
  output logic [REG_W-1:0] q // Held value
);

  logic [REG_W-1:0] next_q;

  // Only implemented positions take the write; the rest stay at zero
  always_comb begin
    next_q = q;
    if (wr) begin
      next_q = wdata & MASK;
    end
  end

  // Every bit clears at reset
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      q <= REG_RESET;
    end else begin
      q <= next_q;
    end
  end

  unimpl_bits_a: assert property (
    @(posedge clk) disable iff (reset) (q & ~MASK) == 8'h00)
    else $error("unimplemented bit became set");

  field_hold_a: assert property (
    @(posedge clk) disable iff (reset) !$past(wr) |-> $stable(q))
    else $error("field changed without a write");

endmodule

`default_nettype wire

// [port_cfg_pkg.sv]
package port_cfg_pkg;

  // Register bus geometry
  localparam int ADR_W = 18;
  localparam int DAT_W = 32;
  localparam int REG_W = 8;
  localparam int NUM_REGS = 7;

  // Register indices; the byte address is four times the index
  localparam logic [15:0] IDX_PORT6_DIRECTION = 16'hFFE9;
  localparam logic [15:0] IDX_PORT7_DIRECTION = 16'hFFEA;
  localparam logic [15:0] IDX_PORT8_DIRECTION = 16'hFFEB;
  localparam logic [15:0] IDX_PORT9_DIRECTION = 16'hFFEC;
  localparam logic [15:0] IDX_PORT1_PULLUP_CONTROL = 16'hFFED;
  localparam logic [15:0] IDX_PORT3_PULLUP_CONTROL = 16'hFFEE;
  localparam logic [15:0] IDX_PORT5_PULLUP_CONTROL = 16'hFFEF;

  // Slot numbers inside the register bank, in index order
  localparam int SLOT_PORT6 = 0;
  localparam int SLOT_PORT7 = 1;
  localparam int SLOT_PORT8 = 2;
  localparam int SLOT_PORT9 = 3;
  localparam int SLOT_PUP1 = 4;
  localparam int SLOT_PUP3 = 5;
  localparam int SLOT_PUP5 = 6;
  localparam logic [2:0] SLOT_NONE = 3'h7;

  // Implemented bits and readability per slot; one reset value shared by all slots
  localparam logic [NUM_REGS-1:0][REG_W-1:0] REG_MASK = {
    8'hFF, 8'h3F, 8'hFF, 8'h1F, 8'hFF, 8'hFF, 8'hFF};
  localparam logic [NUM_REGS-1:0] REG_READABLE = 7'h70;
  localparam logic [REG_W-1:0] REG_RESET = 8'h00;

  // Field widths of the port outputs
  localparam int PORT9_PINS = 5;
  localparam int PORT3_PINS = 6;

  // Write request carried from the bus decode to the register bank
  typedef struct packed {
    logic wr;
    logic [2:0] slot;
    logic [REG_W-1:0] data;
  } reg_write_t;

  // Byte address of a register index
  function automatic logic [ADR_W-1:0] byte_addr(input logic [15:0] idx);
    byte_addr = {idx, 2'b00};
  endfunction

endpackage

// [port_cfg_regs.sv]
// Notes on behaviour
// - A direction bit of 0 makes its pin an input and 1 makes it an output.
// - Port 6 direction is eight write-only bits at its own address, all zero after reset.
// - Port 9 direction holds writable bits 4 down to 0 only, cleared at reset.
// - Port 1 pull-up control is eight readable and writable bits, all zero after reset.
//
// The Wishbone register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

module port_cfg_regs
  import port_cfg_pkg::*;
(
  input wire logic CLK_SYS, // 25 MHz system clock
  input wire logic RESET, // Asynchronous reset, active high
  input wire logic WB_CYC_I, // Bus cycle
  input wire logic WB_STB_I, // Strobe
  input wire logic WB_WE_I, // Write enable
  input wire logic [ADR_W-1:0] WB_ADR_I, // Byte address
  input wire logic [3:0] WB_SEL_I, // Byte lane selects
  input wire logic [DAT_W-1:0] WB_DAT_I, // Write data
  output logic [DAT_W-1:0] WB_DAT_O, // Read data
  output logic WB_ACK_O, // Acknowledge
  output logic [REG_W-1:0] PORT6_DIR, // Port 6 output enables
  output logic [REG_W-1:0] PORT7_DIR, // Port 7 output enables
  output logic [REG_W-1:0] PORT8_DIR, // Port 8 output enables
  output logic [PORT9_PINS-1:0] PORT9_DIR, // Port 9 output enables
  output logic [REG_W-1:0] PORT1_PULLUP, // Port 1 pull-up enables
  output logic [PORT3_PINS-1:0] PORT3_PULLUP, // Port 3 pull-up enables
  output logic [REG_W-1:0] PORT5_PULLUP // Port 5 pull-up enables
);

  logic [REG_W-1:0] q [NUM_REGS];
  logic take;
  logic [2:0] hit;
  reg_write_t wreq;
  logic next_ack;
  logic [DAT_W-1:0] next_dat;

  // Map a byte address to a bank slot; unmapped addresses give SLOT_NONE
  function automatic logic [2:0] slot_of(input logic [ADR_W-1:0] adr);
    slot_of = SLOT_NONE;
    if (adr == byte_addr(IDX_PORT6_DIRECTION)) slot_of = 3'(SLOT_PORT6);
    if (adr == byte_addr(IDX_PORT7_DIRECTION)) slot_of = 3'(SLOT_PORT7);
    if (adr == byte_addr(IDX_PORT8_DIRECTION)) slot_of = 3'(SLOT_PORT8);
    if (adr == byte_addr(IDX_PORT9_DIRECTION)) slot_of = 3'(SLOT_PORT9);
    if (adr == byte_addr(IDX_PORT1_PULLUP_CONTROL)) slot_of = 3'(SLOT_PUP1);
    if (adr == byte_addr(IDX_PORT3_PULLUP_CONTROL)) slot_of = 3'(SLOT_PUP3);
    if (adr == byte_addr(IDX_PORT5_PULLUP_CONTROL)) slot_of = 3'(SLOT_PUP5);
  endfunction

  // A request is taken once, in the cycle before the acknowledge
  always_comb begin
    take = WB_CYC_I && WB_STB_I && !WB_ACK_O;
    hit = slot_of(WB_ADR_I);
    wreq.wr = take && WB_WE_I && WB_SEL_I[0] && (hit != SLOT_NONE);
    wreq.slot = hit;
    wreq.data = WB_DAT_I[REG_W-1:0];
  end

  // One held field per register; writes land at the taking edge
  for (genvar i = 0; i < NUM_REGS; i++) begin : g_bank
    cfg_field #(
      .MASK(REG_MASK[i])
    ) u_field (
      .clk(CLK_SYS),
      .reset(RESET),
      .wr(wreq.wr && (wreq.slot == 3'(i))),
      .wdata(wreq.data),
      .q(q[i])
    );
  end

  // Write-only registers and unmapped addresses read as zero
  always_comb begin
    next_ack = take;
    next_dat = WB_DAT_O;
    if (take) begin
      next_dat = '0;
      if (!WB_WE_I && hit != SLOT_NONE && REG_READABLE[hit]) begin
        next_dat[REG_W-1:0] = q[hit];
      end
    end
  end

  // Bus answer registers; ack is a one-cycle pulse
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= '0;
    end else begin
      WB_ACK_O <= next_ack;
      WB_DAT_O <= next_dat;
    end
  end

  // Pin configuration straight from the field flip-flops; 1 drives the pin in a direction field and enables the pull-up in a pull-up field
  always_comb begin
    PORT6_DIR = q[SLOT_PORT6];
    PORT7_DIR = q[SLOT_PORT7];
    PORT8_DIR = q[SLOT_PORT8];
    PORT9_DIR = q[SLOT_PORT9][PORT9_PINS-1:0];
    PORT1_PULLUP = q[SLOT_PUP1];
    PORT3_PULLUP = q[SLOT_PUP3][PORT3_PINS-1:0];
    PORT5_PULLUP = q[SLOT_PUP5];
  end

  // Request shapes used by the checks below
  sequence wr_port6_s;
    WB_CYC_I && WB_STB_I && !WB_ACK_O && WB_WE_I && WB_SEL_I[0]
      && WB_ADR_I == byte_addr(IDX_PORT6_DIRECTION);
  endsequence

  sequence wr_port9_s;
    WB_CYC_I && WB_STB_I && !WB_ACK_O && WB_WE_I && WB_SEL_I[0]
      && WB_ADR_I == byte_addr(IDX_PORT9_DIRECTION);
  endsequence

  sequence rd_s(logic [ADR_W-1:0] a);
    WB_CYC_I && WB_STB_I && !WB_ACK_O && !WB_WE_I && WB_ADR_I == a;
  endsequence

  sequence ack_pulse_s;
    WB_ACK_O ##1 !WB_ACK_O;
  endsequence

  ack_pulse_a: assert property (
    @(posedge CLK_SYS) disable iff (RESET)
    (WB_CYC_I && WB_STB_I && !WB_ACK_O) |=> ack_pulse_s)
    else $error("ack not a single pulse one cycle after request");

  port6_write_a: assert property (
    @(posedge CLK_SYS) disable iff (RESET)
    wr_port6_s |=> WB_ACK_O && PORT6_DIR == $past(WB_DAT_I[7:0]))
    else $error("port 6 direction did not take the write");

  port6_readzero_a: assert property (
    @(posedge CLK_SYS) disable iff (RESET)
    rd_s(byte_addr(IDX_PORT6_DIRECTION)) |=> WB_ACK_O && WB_DAT_O == '0)
    else $error("write-only port 6 direction returned data");

  port9_write_a: assert property (
    @(posedge CLK_SYS) disable iff (RESET)
    wr_port9_s |=> PORT9_DIR == $past(WB_DAT_I[4:0]) && q[SLOT_PORT9][7:5] == 3'h0)
    else $error("port 9 direction bits wrong after write");

  pullup1_read_a: assert property (
    @(posedge CLK_SYS) disable iff (RESET)
    rd_s(byte_addr(IDX_PORT1_PULLUP_CONTROL)) |=>
      WB_ACK_O && WB_DAT_O == {24'h000000, PORT1_PULLUP})
    else $error("port 1 pull-up readback mismatch");

  dir_stable_a: assert property (
    @(posedge CLK_SYS) disable iff (RESET)
    !(WB_CYC_I && WB_STB_I && WB_WE_I) |=> $stable(PORT7_DIR) && $stable(PORT8_DIR))
    else $error("direction changed without a bus write");

  // Any taken write with lane zero on, at a given register address
  sequence wr_s(logic [ADR_W-1:0] a);
    WB_CYC_I && WB_STB_I && !WB_ACK_O && WB_WE_I && WB_SEL_I[0] && WB_ADR_I == a;
  endsequence

  // Reset clears every control bit; checked one edge later since reset is asynchronous
  reset_dir_a: assert property (
    @(posedge CLK_SYS) RESET |=> PORT6_DIR == '0 && PORT7_DIR == '0 && PORT8_DIR == '0
      && PORT9_DIR == '0 && !WB_ACK_O)
    else $error("direction bits not cleared by reset");

  reset_pullup_a: assert property (
    @(posedge CLK_SYS) RESET |=> PORT1_PULLUP == '0 && PORT3_PULLUP == '0
      && PORT5_PULLUP == '0)
    else $error("pull-up bits not cleared by reset");

  // Each register takes its byte at the taking edge
  port7_write_a: assert property (
    @(posedge CLK_SYS) disable iff (RESET)
    wr_s(byte_addr(IDX_PORT7_DIRECTION)) |=> PORT7_DIR == $past(WB_DAT_I[REG_W-1:0]))
    else $error("port 7 direction did not take the write");

  port8_write_a: assert property (
    @(posedge CLK_SYS) disable iff (RESET)
    wr_s(byte_addr(IDX_PORT8_DIRECTION)) |=> PORT8_DIR == $past(WB_DAT_I[REG_W-1:0]))
    else $error("port 8 direction did not take the write");

  pullup1_write_a: assert property (
    @(posedge CLK_SYS) disable iff (RESET)
    wr_s(byte_addr(IDX_PORT1_PULLUP_CONTROL)) |=> PORT1_PULLUP == $past(WB_DAT_I[REG_W-1:0]))
    else $error("port 1 pull-up did not take the write");

  // Port 3 keeps its two missing bits at zero however it is written
  pullup3_write_a: assert property (
    @(posedge CLK_SYS) disable iff (RESET)
    wr_s(byte_addr(IDX_PORT3_PULLUP_CONTROL)) |=> PORT3_PULLUP == $past(WB_DAT_I[PORT3_PINS-1:0])
      && q[SLOT_PUP3][REG_W-1:PORT3_PINS] == '0)
    else $error("port 3 pull-up bits wrong after write");

  pullup3_read_a: assert property (
    @(posedge CLK_SYS) disable iff (RESET)
    rd_s(byte_addr(IDX_PORT3_PULLUP_CONTROL)) |=> WB_ACK_O && WB_DAT_O[DAT_W-1:PORT3_PINS] == '0
      && WB_DAT_O[PORT3_PINS-1:0] == PORT3_PULLUP)
    else $error("port 3 pull-up readback mismatch");

  port9_readzero_a: assert property (
    @(posedge CLK_SYS) disable iff (RESET)
    rd_s(byte_addr(IDX_PORT9_DIRECTION)) |=> WB_ACK_O && WB_DAT_O == '0)
    else $error("write-only port 9 direction returned data");

  // Without a taken lane-zero write no configuration bit may move
  dir_hold_a: assert property (
    @(posedge CLK_SYS) disable iff (RESET)
    !(WB_CYC_I && WB_STB_I && !WB_ACK_O && WB_WE_I && WB_SEL_I[0])
      |=> $stable(PORT6_DIR) && $stable(PORT9_DIR))
    else $error("direction changed without a taken write");

  pullup_hold_a: assert property (
    @(posedge CLK_SYS) disable iff (RESET)
    !(WB_CYC_I && WB_STB_I && !WB_ACK_O && WB_WE_I && WB_SEL_I[0])
      |=> $stable(PORT1_PULLUP) && $stable(PORT3_PULLUP) && $stable(PORT5_PULLUP))
    else $error("pull-up changed without a taken write");

  // Registers are one byte wide, so the upper read lanes stay at zero
  dat_upper_a: assert property (
    @(posedge CLK_SYS) disable iff (RESET)
    WB_ACK_O |-> WB_DAT_O[DAT_W-1:REG_W] == '0)
    else $error("read data above the register byte not zero");

endmodule

`default_nettype wire

// [port_direction_pullup_regs_bench.sv]
`timescale 1ns/1ps
`default_nettype none

module port_direction_pullup_regs_bench;
  import port_cfg_pkg::*;

  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [ADR_W-1:0] adr = '0;
  logic [3:0] sel = 4'h0;
  logic [DAT_W-1:0] wdat = '0;
  logic [DAT_W-1:0] rdat;
  logic ack;
  logic [7:0] p6, p7, p8, p1, p5;
  logic [4:0] p9;
  logic [5:0] p3;
  int err_total = 0;
  int samples_checked = 0;
  // Reference register model; masks hold the implemented bits per slot
  logic [7:0] mdl [7];
  logic [7:0] msk [7] = '{8'hFF, 8'hFF, 8'hFF, 8'h1F, 8'hFF, 8'h3F, 8'hFF};

  port_cfg_regs uut (
    .CLK_SYS(clk_sys), .RESET(reset), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat),
    .WB_DAT_O(rdat), .WB_ACK_O(ack), .PORT6_DIR(p6), .PORT7_DIR(p7),
    .PORT8_DIR(p8), .PORT9_DIR(p9), .PORT1_PULLUP(p1), .PORT3_PULLUP(p3),
    .PORT5_PULLUP(p5)
  );

  // 25 MHz system clock
  initial begin
    forever #20 clk_sys = ~clk_sys;
  end

  // Single exit point of the run
  task automatic complete_run;
    $display("Checks made %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic report(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Read data compare
  task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
    report({32'h0, got}, {32'h0, exp});
  endtask

  // Pin state compare, all seven fields at once
  task automatic chk_pins;
    report({13'h0, p6, p7, p8, p9, p1, p3, p5},
           {13'h0, mdl[0], mdl[1], mdl[2], mdl[3][4:0], mdl[4], mdl[5][5:0], mdl[6]});
  endtask

  // Classic single cycle; a hang ends the run rather than stalling it
  task automatic bus(input logic w, input int i, input logic [7:0] d, input logic [3:0] s,
                     output logic [31:0] r);
    int n;
    @(posedge clk_sys);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {16'(IDX_PORT6_DIRECTION + i), 2'b00};
    sel <= s;
    wdat <= {24'($urandom), d};
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (ack !== 1'b1 && n < 16);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1) begin
      err_total++;
      $display("[ERR] t=%0t ack=%h exp=%h", $time, ack, 1'b1);
      complete_run();
    end
  endtask

  task automatic wr(input int i, input logic [7:0] d, input logic [3:0] s);
    logic [31:0] r;
    bus(1'b1, i, d, s, r);
    if (s[0] && i >= 0 && i < 7) begin
      mdl[i] = d & msk[i];
    end
    chk_pins();
  endtask

  // Pull-up slots read back; direction slots and holes read zero
  task automatic rd(input int i);
    logic [31:0] r;
    bus(1'b0, i, 8'h00, 4'hF, r);
    chk_rd(r, (i >= 4 && i < 7) ? {24'h0, mdl[i]} : 32'h0);
  endtask

  task automatic do_reset;
    @(posedge clk_sys);
    reset <= 1'b1;
    foreach (mdl[k]) mdl[k] = 8'h00;
    repeat (2) @(posedge clk_sys);
    chk_pins();
    reset <= 1'b0;
  endtask

  initial begin
    int i;
    void'($urandom(32'h9AB1));
    do_reset();
    for (i = 0; i < 7; i++) rd(i);
    // All ones shows exactly which bits exist
    for (i = 0; i < 7; i++) wr(i, 8'hFF, 4'h1);
    for (i = 0; i < 7; i++) rd(i);
    // Random traffic, including holes either side and lane zero off
    for (int k = 0; k < 80; k++) begin
      i = int'($urandom % 9) - 1;
      wr(i, 8'($urandom), 4'($urandom));
      rd(i);
    end
    for (i = 0; i < 7; i++) wr(i, 8'($urandom), 4'hF);
    do_reset();
    for (i = 0; i < 7; i++) rd(i);
    complete_run();
  end
endmodule

`default_nettype wire
